// ===== core/sp_ctrl.sv
// Purpose: serial peripheral controller: registers, fifos, master engine, slave link
// Assumes: i_clk 20 MHz; slave link clocked by the external serial clock
// Notes:   fifo depth is a power of two
`timescale 1ns/1ns

module sp_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_clr,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data,
    output logic [AW:0] o_level
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sp_fifo_st_t;

    sp_fifo_st_t q;
    sp_fifo_st_t n;
    logic push;
    logic pop;

    assign o_in_ready = (q.cnt != (AW+1)'(DEPTH)) && !i_clr;
    assign o_out_valid = (q.cnt != '0) && !i_clr;
    assign o_out_data = q.mem[q.rp];
    assign o_level = q.cnt;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wp] = i_in_data;
            n.wp = q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = q.rp + 1'b1;
        end
        n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_clr) begin
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

// ----------------------------------------------------------------
// slave side shift logic on the link clock
// ----------------------------------------------------------------
module sp_slave_link #(
    parameter int W = 32
) (
    input wire logic i_link_clk,
    input wire logic i_rst,
    input wire logic i_mosi,
    input wire logic [4:0] i_len,
    input wire logic [W-1:0] i_tx_word,
    output logic [W-1:0] o_rx_word,
    output logic o_done_tgl,
    output logic o_miso
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [W-1:0] sh;
        logic [W-1:0] rxw;
        logic tgl;
    } sp_link_st_t;

    sp_link_st_t q;
    sp_link_st_t n;
    logic [W-1:0] mask;
    logic [4:0] idx;

    assign mask = {W{1'b1}} >> (5'(W - 1) - i_len);
    assign idx = i_len - q.cnt;
    assign o_rx_word = q.rxw;
    assign o_done_tgl = q.tgl;

    always_comb begin
        n = q;
        n.sh = {q.sh[W-2:0], i_mosi};
        if (q.cnt == i_len) begin
            n.cnt = '0;
            n.rxw = n.sh & mask;
            n.tgl = !q.tgl;
        end else begin
            n.cnt = q.cnt + 5'd1;
        end
        if (i_rst) begin
            n = '0;
        end
    end

    // capture on the rising edge of the normalised clock
    always_ff @(posedge i_link_clk) begin
        q <= n;
    end

    // launch on the opposite edge
    always_ff @(negedge i_link_clk) begin
        if (i_rst) begin
            o_miso <= 1'b0;
        end else begin
            o_miso <= i_tx_word[idx];
        end
    end
endmodule

// ----------------------------------------------------------------
// top: register file, master engine, slave glue
// ----------------------------------------------------------------
module sp_ctrl #(
    parameter int W = sp_pkg::DATA_W,
    parameter int DEPTH = sp_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_dma_rx_req,
    output logic o_dma_tx_req,
    output logic o_sclk,
    output logic o_sclk_oe,
    input wire logic i_link_sclk,
    output logic o_mosi,
    output logic o_mosi_oe,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_miso,
    output logic o_cs_n,
    input wire logic i_cs_n
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cfg;
        logic [7:0] clk;
        logic [7:0] fcfg;
        logic [15:0] high_wr;
        logic [15:0] high_rd;
        logic ovfl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic dma_rx;
        logic dma_tx;
        sp_pkg::sp_mstate_t st;
        logic [6:0] div_cnt;
        logic [5:0] edge_cnt;
        logic [W-1:0] txsh;
        logic [W-1:0] rxsh;
        logic late_pend;
        logic sclk;
        logic sclk_oe;
        logic mosi;
        logic mosi_oe;
        logic cs_n;
        logic miso_oe;
        logic miso_s1;
        logic miso_s2;
        logic csn_s1;
        logic csn_s2;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic [W-1:0] stx;
        logic stx_ok;
        logic link_rst;
    } sp_top_st_t;

    sp_top_st_t q;
    sp_top_st_t n;

    logic en, tx_en, rx_en, slave, cpol, cpha, fifo_clr;
    logic [1:0] mode;
    logic [4:0] wlen;
    logic [6:0] half;
    logic setup, wr_acc, tick, cap_edge, last_edge, rx_thr, tx_thr, start_ok;
    logic tx_push, tx_ready, tx_valid, tx_pop;
    logic rx_push, rx_ready, rx_valid, rx_pop;
    logic [W-1:0] tx_push_data, tx_data, rx_push_data, rx_data, link_rx;
    logic [AW:0] tx_lvl, rx_lvl;
    logic link_clk, link_tgl;

    function automatic logic [15:0] swap16(input logic [15:0] d, input logic s);
        swap16 = s ? {d[7:0], d[15:8]} : d;
    endfunction

    assign en = q.ctrl[sp_pkg::CTRL_EN];
    assign tx_en = q.ctrl[sp_pkg::CTRL_TX_EN];
    assign rx_en = q.ctrl[sp_pkg::CTRL_RX_EN];
    assign fifo_clr = q.ctrl[sp_pkg::CTRL_FIFO_RST];
    assign slave = q.cfg[sp_pkg::CFG_SLAVE];
    assign mode = q.cfg[sp_pkg::CFG_MODE_LSB +: 2];
    assign wlen = q.cfg[sp_pkg::CFG_LEN_LSB +: 5];
    assign cpol = mode[1];
    assign cpha = mode[0];
    assign half = (q.clk[sp_pkg::CLK_DIV_LSB +: 7] == sp_pkg::CLK_DIV_FAST) ? 7'h00
                : q.clk[sp_pkg::CLK_DIV_LSB +: 7];
    assign rx_thr = 5'(rx_lvl) >= (5'(q.fcfg[sp_pkg::FCFG_RX_TL_LSB +: 4]) + 5'd1);
    assign tx_thr = 5'(tx_lvl) <= 5'(q.fcfg[sp_pkg::FCFG_TX_TL_LSB +: 4]);
    // slave capture edge maps to the rising edge of this clock
    assign link_clk = i_link_sclk ^ (mode[1] ^ mode[0]);

    sp_fifo #(.W(W), .DEPTH(DEPTH)) u_tx_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clr(fifo_clr),
        .i_in_valid(tx_push),
        .o_in_ready(tx_ready),
        .i_in_data(tx_push_data),
        .o_out_valid(tx_valid),
        .i_out_ready(tx_pop),
        .o_out_data(tx_data),
        .o_level(tx_lvl)
    );

    sp_fifo #(.W(W), .DEPTH(DEPTH)) u_rx_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clr(fifo_clr),
        .i_in_valid(rx_push),
        .o_in_ready(rx_ready),
        .i_in_data(rx_push_data),
        .o_out_valid(rx_valid),
        .i_out_ready(rx_pop),
        .o_out_data(rx_data),
        .o_level(rx_lvl)
    );

    sp_slave_link #(.W(W)) u_link (
        .i_link_clk(link_clk),
        .i_rst(q.link_rst),
        .i_mosi(i_mosi),
        .i_len(wlen),
        .i_tx_word(q.stx),
        .o_rx_word(link_rx),
        .o_done_tgl(link_tgl),
        .o_miso(o_miso)
    );

    always_comb begin
        n = q;
        tx_push = 1'b0;
        tx_push_data = '0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_push_data = '0;
        rx_pop = 1'b0;
        n.miso_s1 = i_miso;
        n.miso_s2 = q.miso_s1;
        n.csn_s1 = i_cs_n;
        n.csn_s2 = q.csn_s1;
        n.tgl_s1 = link_tgl;
        n.tgl_s2 = q.tgl_s1;
        n.tgl_s3 = q.tgl_s2;

        // ------------------------------------------------------------
        // register access: setup cycle answers, access cycle writes
        // ------------------------------------------------------------
        setup = i_psel && !i_penable;
        wr_acc = i_psel && i_penable && q.pready && i_pwrite && !q.pslverr;
        n.pready = setup;
        // error stands only alongside ready
        n.pslverr = 1'b0;
        if (setup) begin
            n.prdata = '0;
            unique case (i_paddr)
                sp_pkg::CTRL_ADDR: n.prdata = 32'(q.ctrl);
                sp_pkg::CFG_ADDR: n.prdata = 32'(q.cfg);
                sp_pkg::CLK_ADDR: n.prdata = 32'(q.clk);
                sp_pkg::FCFG_ADDR: n.prdata = 32'(q.fcfg);
                sp_pkg::STAT_ADDR: begin
                    n.prdata[sp_pkg::STAT_RX_THR] = rx_thr;
                    n.prdata[sp_pkg::STAT_TX_THR] = tx_thr;
                end
                sp_pkg::FSTAT_ADDR: begin
                    n.prdata[sp_pkg::LEVEL_W-1:0] = sp_pkg::LEVEL_W'(rx_lvl);
                    n.prdata[sp_pkg::FST_TX_LVL_LSB +: sp_pkg::LEVEL_W] =
                        sp_pkg::LEVEL_W'(tx_lvl);
                    n.prdata[sp_pkg::FST_RX_EMPTY] = !rx_valid;
                    n.prdata[sp_pkg::FST_TX_FULL] = !tx_ready;
                    n.prdata[sp_pkg::FST_OVFL] = q.ovfl;
                    n.prdata[sp_pkg::FST_ACTIVE] = (q.st != sp_pkg::MS_IDLE);
                end
                sp_pkg::RD_ADDR: begin
                    if (!i_pwrite && rx_valid) begin
                        rx_pop = 1'b1;
                        n.prdata[15:0] = swap16(rx_data[15:0],
                                                q.ctrl[sp_pkg::CTRL_SWAP]);
                        n.high_rd = rx_data[31:16];
                    end
                end
                sp_pkg::WR_ADDR: n.prdata = '0;
                sp_pkg::HIGH_ADDR: n.prdata = 32'(q.high_rd);
                default: n.pslverr = 1'b1;
            endcase
        end
        if (wr_acc) begin
            unique case (i_paddr)
                sp_pkg::CTRL_ADDR: n.ctrl = i_pwdata[7:0];
                sp_pkg::CFG_ADDR: n.cfg = i_pwdata[7:0];
                sp_pkg::CLK_ADDR: n.clk = i_pwdata[7:0];
                sp_pkg::FCFG_ADDR: n.fcfg = i_pwdata[7:0];
                sp_pkg::HIGH_ADDR: n.high_wr = i_pwdata[15:0];
                sp_pkg::WR_ADDR: begin
                    tx_push = tx_ready;
                    tx_push_data = {q.high_wr, swap16(i_pwdata[15:0],
                                                      q.ctrl[sp_pkg::CTRL_SWAP])};
                end
                default: n.prdata = q.prdata;
            endcase
        end
        if (fifo_clr) begin
            n.ovfl = 1'b0;
        end

        // ------------------------------------------------------------
        // master engine
        // ------------------------------------------------------------
        n.sclk_oe = en && !slave;
        tick = (q.div_cnt == half);
        cap_edge = (q.edge_cnt[0] == cpha);
        last_edge = (q.edge_cnt == {wlen, 1'b1});
        // rx-only is started only when the first edge captures
        start_ok = tx_en ? tx_valid : (rx_en && !cpha && rx_ready);
        unique case (q.st)
            sp_pkg::MS_IDLE: begin
                n.sclk = cpol;
                n.cs_n = 1'b1;
                n.mosi_oe = 1'b0;
                n.late_pend = 1'b0;
                if (en && !slave && start_ok && !fifo_clr) begin
                    tx_pop = tx_en;
                    n.txsh = tx_en ? tx_data : '0;
                    n.rxsh = '0;
                    n.cs_n = 1'b0;
                    n.mosi_oe = 1'b1;
                    n.div_cnt = '0;
                    n.edge_cnt = '0;
                    if (!cpha) begin
                        n.mosi = n.txsh[wlen];
                        n.txsh = n.txsh << 1;
                    end
                    n.st = sp_pkg::MS_SHIFT;
                end
            end
            sp_pkg::MS_SHIFT: begin
                n.div_cnt = q.div_cnt + 7'd1;
                if (tick) begin
                    n.div_cnt = '0;
                    n.sclk = !q.sclk;
                    n.edge_cnt = q.edge_cnt + 6'd1;
                    if (q.late_pend) begin
                        n.rxsh = {q.rxsh[W-2:0], q.miso_s2};
                        n.late_pend = 1'b0;
                    end
                    if (cap_edge) begin
                        if (q.ctrl[sp_pkg::CTRL_LATE]) begin
                            n.late_pend = 1'b1;
                        end else begin
                            n.rxsh = {q.rxsh[W-2:0], q.miso_s2};
                        end
                    end else begin
                        n.mosi = q.txsh[wlen];
                        n.txsh = q.txsh << 1;
                    end
                    if (last_edge) begin
                        n.st = n.late_pend ? sp_pkg::MS_LATE : sp_pkg::MS_DONE;
                    end
                end
            end
            sp_pkg::MS_LATE: begin
                n.div_cnt = q.div_cnt + 7'd1;
                if (tick) begin
                    n.div_cnt = '0;
                    n.rxsh = {q.rxsh[W-2:0], q.miso_s2};
                    n.late_pend = 1'b0;
                    n.st = sp_pkg::MS_DONE;
                end
            end
            sp_pkg::MS_DONE: begin
                if (rx_en) begin
                    rx_push = 1'b1;
                    rx_push_data = q.rxsh;
                    if (!rx_ready) begin
                        n.ovfl = 1'b1;
                    end
                end
                n.cs_n = 1'b1;
                n.st = sp_pkg::MS_IDLE;
            end
        endcase
        if (!en || slave) begin
            n.st = sp_pkg::MS_IDLE;
            n.sclk = cpol;
            n.cs_n = 1'b1;
            n.mosi_oe = 1'b0;
        end

        // ------------------------------------------------------------
        // slave glue: word events arrive as a toggle
        // ------------------------------------------------------------
        n.link_rst = i_srst || !en || !slave;
        n.miso_oe = en && slave && !q.csn_s2;
        if (en && slave) begin
            if (q.tgl_s2 != q.tgl_s3) begin
                n.stx_ok = 1'b0;
                if (rx_en) begin
                    rx_push = 1'b1;
                    rx_push_data = link_rx;
                    if (!rx_ready) begin
                        n.ovfl = 1'b1;
                    end
                end
            end
            if ((!q.stx_ok || (q.tgl_s2 != q.tgl_s3)) && tx_en && tx_valid) begin
                tx_pop = 1'b1;
                n.stx = tx_data;
                n.stx_ok = 1'b1;
            end
        end else begin
            n.stx_ok = 1'b0;
        end
        if (fifo_clr) begin
            n.stx_ok = 1'b0;
        end

        // ------------------------------------------------------------
        // dma requests
        // ------------------------------------------------------------
        n.dma_rx = en && rx_en && q.ctrl[sp_pkg::CTRL_DMA_RX] && rx_thr;
        n.dma_tx = en && tx_en && q.ctrl[sp_pkg::CTRL_DMA_TX] && tx_thr;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
            q.ctrl <= sp_pkg::CTRL_RST;
            q.cfg <= sp_pkg::CFG_RST;
            q.clk <= sp_pkg::CLK_RST;
            q.fcfg <= sp_pkg::FCFG_RST;
            q.st <= sp_pkg::MS_IDLE;
            q.cs_n <= 1'b1;
            q.csn_s1 <= 1'b1;
            q.csn_s2 <= 1'b1;
            q.link_rst <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign o_prdata = q.prdata;
    assign o_pready = q.pready;
    assign o_pslverr = q.pslverr;
    assign o_dma_rx_req = q.dma_rx;
    assign o_dma_tx_req = q.dma_tx;
    assign o_sclk = q.sclk;
    assign o_sclk_oe = q.sclk_oe;
    assign o_mosi = q.mosi;
    assign o_mosi_oe = q.mosi_oe;
    assign o_miso_oe = q.miso_oe;
    assign o_cs_n = q.cs_n;
endmodule

// ===== core/sp_pkg.sv
// Purpose: shared constants and types of the serial peripheral controller
// Assumes: 32-bit APB-style access, registers at fixed absolute addresses
// Notes:   control and configuration fields are indexed through these names
package sp_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W = 6;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1200;
    localparam logic [31:0] CFG_ADDR = 32'h5000_1204;
    localparam logic [31:0] CLK_ADDR = 32'h5000_1208;
    localparam logic [31:0] FCFG_ADDR = 32'h5000_120C;
    localparam logic [31:0] STAT_ADDR = 32'h5000_1214;
    localparam logic [31:0] FSTAT_ADDR = 32'h5000_1218;
    localparam logic [31:0] RD_ADDR = 32'h5000_121C;
    localparam logic [31:0] WR_ADDR = 32'h5000_1220;
    localparam logic [31:0] HIGH_ADDR = 32'h5000_1228;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_TX_EN = 1;
    localparam int CTRL_RX_EN = 2;
    localparam int CTRL_DMA_TX = 3;
    localparam int CTRL_DMA_RX = 4;
    localparam int CTRL_FIFO_RST = 5;
    localparam int CTRL_LATE = 6;
    localparam int CTRL_SWAP = 7;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_LEN_LSB = 2;
    localparam int CFG_SLAVE = 7;
    localparam int CLK_DIV_LSB = 0;
    localparam int FCFG_TX_TL_LSB = 0;
    localparam int FCFG_RX_TL_LSB = 4;
    localparam int FST_TX_LVL_LSB = 6;
    localparam int FST_RX_EMPTY = 12;
    localparam int FST_TX_FULL = 13;
    localparam int FST_OVFL = 14;
    localparam int FST_ACTIVE = 15;
    localparam int STAT_TX_THR = 0;
    localparam int STAT_RX_THR = 1;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CLK_RST = 8'h00;
    localparam logic [7:0] FCFG_RST = 8'h00;
    localparam logic [6:0] CLK_DIV_FAST = 7'h7F;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_SHIFT = 2'b01,
        MS_LATE = 2'b10,
        MS_DONE = 2'b11
    } sp_mstate_t;

endpackage

// ===== sim/sp_ctrl_asserts.sv
// Purpose: port-level checks of the serial controller
// Assumes: bound to sp_ctrl, one clock domain
// Notes: ready, chip-select and drive-enable relations only
`timescale 1ns/1ns
module sp_ctrl_asserts (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_sclk_oe,
    input wire logic o_mosi_oe,
    input wire logic o_miso_oe,
    input wire logic o_cs_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_cs_word_held: assert property ($fell(o_cs_n) |=> !o_cs_n || !o_sclk_oe)
        else $error("select released right after start");
    a_cs_needs_master: assert property (!o_cs_n |-> o_sclk_oe)
        else $error("select low outside master role");
    a_one_role: assert property (!(o_sclk_oe && o_miso_oe))
        else $error("both roles drive");
    a_mosi_master: assert property (o_mosi_oe |-> o_sclk_oe)
        else $error("data driven outside master role");
    a_abort_idle: assert property ($fell(o_sclk_oe) |-> o_cs_n)
        else $error("word not stopped on disable");
endmodule

bind sp_ctrl sp_ctrl_asserts i_sp_ctrl_asserts (.i_clk(i_clk), .i_srst(i_srst),
    .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_sclk_oe(o_sclk_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe), .o_cs_n(o_cs_n));

// ===== sim/sp_peer.sv
// Purpose: external 8-bit slave answering master words
// Assumes: clock mode 0, fixed reply per word
// Notes: data line shows the inverse of its last bit when deselected
`timescale 1ns/1ns
module sp_peer #(
    parameter logic [7:0] REPLY = 8'hA5
) (
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic [7:0] o_got
);
    logic [7:0] sr;
    logic drv;
    initial begin
        sr = REPLY;
        drv = 1'b0;
        o_got = 8'h00;
    end
    always @(negedge i_cs_n) begin
        sr = REPLY;
        drv = REPLY[7];
    end
    always @(negedge i_sclk) if (!i_cs_n) begin
        sr = {sr[6:0], 1'b0};
        drv = sr[7];
    end
    always @(posedge i_sclk) if (!i_cs_n) o_got <= {o_got[6:0], i_mosi};
    assign o_miso = i_cs_n ? ~drv : drv;
endmodule

// ===== sim/testbench.sv
// Purpose: self-checking bench of the serial controller
// Assumes: 50 ns module clock, 48 ns link clock in slave frames
// Notes: peer model answers master words
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] SB = 8'h96;
    logic i_clk, i_srst, i_psel, i_penable, i_pwrite, i_link_sclk, i_mosi, i_cs_n, e;
    logic o_pready, o_pslverr, o_dma_rx_req, o_dma_tx_req, o_sclk, o_mosi, o_miso, o_cs_n, pm;
    logic [31:0] i_paddr, i_pwdata, o_prdata, r;
    logic [7:0] got;
    int n_errors = 0;
    int check_count = 0;
    sp_ctrl i_sp_ctrl (.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_dma_rx_req(o_dma_rx_req),
        .o_dma_tx_req(o_dma_tx_req), .o_sclk(o_sclk), .o_sclk_oe(), .i_link_sclk(i_link_sclk),
        .o_mosi(o_mosi), .o_mosi_oe(), .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(),
        .i_miso(pm), .o_cs_n(o_cs_n), .i_cs_n(i_cs_n));
    sp_peer i_sp_peer (.i_sclk(o_sclk), .i_cs_n(o_cs_n), .i_mosi(o_mosi), .o_miso(pm),
        .o_got(got));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // ----
    // bus and checking
    // ----
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(negedge i_clk);
        i_psel = 1'b1;
        i_pwrite = w;
        i_paddr = a;
        i_pwdata = d;
        @(negedge i_clk);
        i_penable = 1'b1;
        for (k = 0; k < 8 && o_pready !== 1'b1; k++) @(negedge i_clk);
        if (k == 8) begin
            chk(0, 1, "bus hang");
            final_report();
        end
        r = o_prdata;
        e = o_pslverr;
        @(negedge i_clk);
        i_psel = 1'b0;
        i_penable = 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] x, input string m);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, x, m);
    endtask
    task automatic wait_word;
        int k;
        for (k = 0; k < 400 && o_cs_n !== 1'b0; k++) @(negedge i_clk);
        for (; k < 400 && o_cs_n !== 1'b1; k++) @(negedge i_clk);
        if (k >= 400) begin
            chk(0, 1, "word hang");
            final_report();
        end
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs;
        rd(sp_pkg::CTRL_ADDR, 32'h0000_0000, "ctrl reset");
        rd(sp_pkg::CFG_ADDR, 32'h0000_0000, "cfg reset");
        apb(1'b0, 32'h5000_1300, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001, "unmapped");
        wr(sp_pkg::CFG_ADDR, 32'h0000_00FF);
        rd(sp_pkg::CFG_ADDR, 32'h0000_00FF, "cfg rw");
        $display("regs done");
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(sp_pkg::CFG_ADDR, 32'(m) | 32'h0000_001C);
            wr(sp_pkg::CTRL_ADDR, 32'h0000_0001);
            repeat (3) @(negedge i_clk);
            chk(32'(o_sclk), 32'(m / 2), "idle level");
            wr(sp_pkg::CTRL_ADDR, 32'h0000_0000);
            chk(32'(o_cs_n), 32'h0000_0001, "no word");
        end
        $display("modes done");
    endtask
    task automatic t_master;
        wr(sp_pkg::CFG_ADDR, 32'h0000_001C);
        wr(sp_pkg::CLK_ADDR, 32'h0000_0083);
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0080);
        wr(sp_pkg::WR_ADDR, 32'h0000_3C00);
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0087);
        wait_word();
        chk(32'(got), 32'h0000_003C, "peer got");
        rd(sp_pkg::RD_ADDR, 32'h0000_A500, "rx swapped");
        wr(sp_pkg::CTRL_ADDR, 32'h0000_00C6);
        wr(sp_pkg::WR_ADDR, 32'h0000_3C00);
        wr(sp_pkg::CTRL_ADDR, 32'h0000_00C7);
        wait_word();
        rd(sp_pkg::RD_ADDR, 32'h0000_A500, "late rx");
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0000);
        $display("master done");
    endtask
    task automatic t_slave_dma;
        wr(sp_pkg::CFG_ADDR, 32'h0000_009C);
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0005);
        i_cs_n = 1'b0;
        repeat (4) @(negedge i_clk);
        for (int i = 7; i >= 0; i--) begin
            i_mosi = SB[i];
            #24 i_link_sclk = 1'b1;
            #24 i_link_sclk = 1'b0;
        end
        i_mosi = ~i_mosi;
        repeat (8) @(negedge i_clk);
        i_cs_n = 1'b1;
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0015);
        repeat (2) @(negedge i_clk);
        chk(32'(o_dma_rx_req), 32'h0000_0001, "rx dma on");
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0011);
        repeat (2) @(negedge i_clk);
        chk(32'(o_dma_rx_req), 32'h0000_0000, "rx dma path off");
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0005);
        rd(sp_pkg::RD_ADDR, 32'h0000_0096, "slave rx");
        for (int j = 0; j < 3; j++) begin
            wr(sp_pkg::CTRL_ADDR, j == 0 ? 32'h0000_000B : j == 1 ? 32'h0000_0009 : 32'h0000_0003);
            repeat (2) @(negedge i_clk);
            chk(32'(o_dma_tx_req), 32'(j == 0), "tx dma");
        end
        $display("slave and dma done");
    endtask
    task automatic t_fifo;
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0000);
        wr(sp_pkg::WR_ADDR, 32'h0000_1234);
        rd(sp_pkg::FSTAT_ADDR, 32'h0000_1040, "one queued");
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0020);
        rd(sp_pkg::FSTAT_ADDR, 32'h0000_3000, "flushed");
        wr(sp_pkg::WR_ADDR, 32'h0000_5678);
        rd(sp_pkg::FSTAT_ADDR, 32'h0000_3000, "held");
        wr(sp_pkg::CTRL_ADDR, 32'h0000_0000);
        $display("fifo done");
    endtask
    initial begin
        {i_srst, i_psel, i_penable, i_pwrite, i_link_sclk, i_mosi} = 6'h3F & 6'h20;
        i_cs_n = 1'b1;
        i_paddr = 32'h0000_0000;
        i_pwdata = 32'h0000_0000;
        repeat (3) @(negedge i_clk);
        i_srst = 1'b0;
        t_regs();
        t_modes();
        t_master();
        t_slave_dma();
        t_fifo();
        final_report();
    end
endmodule
